//--- logic/viau_top.sv
// Vectored interrupt acceptance and return unit with Wishbone registers
`timescale 1ns/1ps
// Notes on behaviour
// (R1) A source request sets its pending flag regardless of any enable.
// (R2) A request block asserts only while pending and permit are both 1.
// (R3) Accept only when some request block asserts and global enable set.
// (R4) Grant order: pin, then timer, then sync, then serial.
// (R5) An asserting block absorbs the grant from lower blocks.
// (R6) Simultaneous requests set all their pending flags in parallel.
// (R7) A source with permit 0 is never accepted.
// (R8) Skip taken or first table-move cycle defers acceptance one cycle.
// (R9) Enable instruction sets global enable one instruction cycle later.
// (R10) Acceptance clears global enable and only the accepted pending flag.
// (R11) Interrupt cycle decrements stack pointer then writes PC there.
// (R12) Saved return address is the sequencer's next address.
// (R13) Interrupt cycle pushes low two bank bits and index enable.
// (R14) Interrupt cycle loads PC with accepted source's vector.
// (R15) All acceptance work fits one special instruction cycle.
// (R16) Return loads PC from stack entry at current stack pointer.
// (R17) Return restores low bank bits and index enable from stack.
// (R18) Return increments stack pointer after PC is restored.
// (R19) Return takes one instruction cycle, like an ordinary return.
// (R20) Vectors: pin 04H, timer 03H, sync 02H, serial 01H.
// (R21) Interrupt stack holds two nesting levels.
// (R22) After the push, bank register and index enable clear to zero.
// (R23) Disable instruction clears global enable in its own cycle.
// (R24) Acceptance only at cycle boundaries, at most one per boundary.
module viau_top (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [3:0] src_req_in,
	input wire logic display_run_in,
	input wire logic skip_taken_in,
	input wire logic table_move_first_in,
	input wire logic enable_irq_instruction_in,
	input wire logic disable_irq_instruction_in,
	input wire logic return_from_irq_instruction_in,
	input wire logic [11:0] return_pc_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [8:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic cycle_boundary_out,
	output logic irq_cycle_out,
	output logic pc_load_out,
	output logic [11:0] pc_value_out,
	output logic [2:0] stack_pointer_out,
	output logic [3:0] bank_out,
	output logic index_enable_out,
	output logic global_irq_enable_out
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	viau_src_if src ();
	logic [11:0] div_reg;
	logic cyc_end;
	viau_pkg::viau_phase_e phase_reg;
	logic gie_reg;
	logic arm_reg;
	logic [3:0] pend_reg;
	logic [3:0] permit_reg;
	logic [2:0] sp_reg;
	viau_pkg::viau_pc_t astk_reg [viau_pkg::ASTK_DEPTH];
	logic [2:0] istk_reg [2];
	logic [1:0] depth_reg;
	logic [3:0] bank_reg;
	logic ixe_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic boundary_reg;
	logic pc_load_reg;
	logic accept;
	logic return_from_irq_instruction_do;
	logic defer;
	logic wb_req;
	logic wb_wr;
	logic [6:0] wb_idx;
	logic [3:0] pend_set;
	logic [3:0] pend_clr;
	viau_pkg::viau_pc_t vec_sel;
	viau_pkg::viau_pc_t astk_top;
	viau_pkg::viau_pc_t pc_value_reg;

	// Write strobe decode, shared by every writable register
	function automatic logic wr_hit(input logic wr, input logic [6:0] a,
		input logic [6:0] idx);
		wr_hit = wr & (a == idx);
	endfunction

	// Vector of the one source holding the grant
	function automatic viau_pkg::viau_pc_t vec_of(input logic [3:0] t);
		vec_of = 12'h000;
		for (int i = 0; i < viau_pkg::NSRC; i++) begin
			if (t[i]) begin
				vec_of = viau_pkg::VECTOR[i];
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Instruction cycle divider
	// ----------------------------------------------------------------
	// Cycle length follows the display controller at each reload
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_reg <= viau_pkg::CYC_LAST;
		end else if (cyc_end) begin
			div_reg <= display_run_in ? viau_pkg::CYC_IDC_LAST :
				viau_pkg::CYC_LAST;
		end else begin
			div_reg <= div_reg - 12'h001;
		end
	end
	assign cyc_end = (div_reg == 12'h000);

	// ----------------------------------------------------------------
	// Acceptance decision
	// ----------------------------------------------------------------
	assign src.pend = pend_reg;
	assign src.permit = permit_reg;

	viau_grant u_grant (
		.s(src)
	);

	// (R8) Skip or first table-move cycle defers
	// A return also defers so the stack is never pushed and popped at once
	assign defer = skip_taken_in | table_move_first_in |
		return_from_irq_instruction_in;
	// (R24) Only at a boundary of a normal instruction cycle
	// (R3) Requires a request and the global enable
	assign accept = cyc_end & (phase_reg == viau_pkg::PH_NORMAL) &
		src.any & gie_reg & ~disable_irq_instruction_in & ~defer;
	// (R19) Return completes at its own boundary
	assign return_from_irq_instruction_do = cyc_end & (phase_reg == viau_pkg::PH_NORMAL) &
		return_from_irq_instruction_in;
	// (R20) Vector of the granted source
	assign vec_sel = vec_of(src.take);
	assign astk_top = (sp_reg < viau_pkg::SP_LIMIT) ? astk_reg[sp_reg] :
		12'h000;

	// (R15) One special cycle with no normal instruction in it
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			phase_reg <= viau_pkg::PH_NORMAL;
		end else begin
			unique case (phase_reg)
				viau_pkg::PH_NORMAL: begin
					if (accept) begin
						phase_reg <= viau_pkg::PH_IRQ;
					end
				end
				viau_pkg::PH_IRQ: begin
					if (cyc_end) begin
						phase_reg <= viau_pkg::PH_NORMAL;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Global enable
	// ----------------------------------------------------------------
	// (R9) Enable arms now and takes effect one cycle later
	// Accept clears the arm so a handler never starts interruptible
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			arm_reg <= 1'b0;
		end else if (disable_irq_instruction_in) begin
			arm_reg <= 1'b0;
		end else if (cyc_end) begin
			arm_reg <= enable_irq_instruction_in & ~accept &
				(phase_reg == viau_pkg::PH_NORMAL);
		end
	end

	// (R23) Disable clears at once; (R10) accept clears too
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gie_reg <= 1'b0;
		end else if (accept || disable_irq_instruction_in) begin
			gie_reg <= 1'b0;
		end else if (cyc_end && arm_reg) begin
			gie_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pending and permit flags
	// ----------------------------------------------------------------
	// (R1) Requests set flags unconditionally; (R6) all bits in parallel
	assign pend_set = src_req_in |
		({4{wr_hit(wb_wr, wb_idx, viau_pkg::IDX_PENDING)}} & wb_dat_in[3:0]);
	// (R10) Only the accepted source is cleared
	assign pend_clr = ({4{accept}} & src.take) |
		({4{wr_hit(wb_wr, wb_idx, viau_pkg::IDX_PENDING)}} &
		~wb_dat_in[3:0]);

	// Set wins over clear so no request is lost
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pend_reg <= viau_pkg::FLAGS_RESET;
		end else begin
			pend_reg <= (pend_reg & ~pend_clr) | pend_set;
		end
	end

	// (R7) Software masks sources through permit
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			permit_reg <= viau_pkg::FLAGS_RESET;
		end else if (wr_hit(wb_wr, wb_idx, viau_pkg::IDX_PERMIT)) begin
			permit_reg <= wb_dat_in[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Address stack and program counter
	// ----------------------------------------------------------------
	// (R11) Pointer moves down, then the entry below is written
	// (R18) Return moves it back up after the read
	// No overflow check: software keeps nesting within six levels
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sp_reg <= viau_pkg::SP_RESET;
		end else if (accept) begin
			sp_reg <= sp_reg - 3'h1;
		end else if (return_from_irq_instruction_do) begin
			sp_reg <= sp_reg + 3'h1;
		end
	end

	// (R12) Return address comes from the sequencer
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < viau_pkg::ASTK_DEPTH; i++) begin
				astk_reg[i] <= 12'h000;
			end
		end else if (accept) begin
			astk_reg[sp_reg - 3'h1] <= return_pc_in;
		end
	end

	// (R14) Vector load on accept; (R16) stack entry on return
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pc_load_reg <= 1'b0;
			pc_value_reg <= 12'h000;
		end else begin
			pc_load_reg <= accept | return_from_irq_instruction_do;
			if (accept) begin
				pc_value_reg <= vec_sel;
			end else if (return_from_irq_instruction_do) begin
				pc_value_reg <= astk_top;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt stack, bank and index enable
	// ----------------------------------------------------------------
	// (R13) Push state; (R21) two levels; (R17) pop on return
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			istk_reg[0] <= 3'h0;
			istk_reg[1] <= 3'h0;
			depth_reg <= 2'h0;
		end else if (accept) begin
			istk_reg[1] <= istk_reg[0];
			istk_reg[0] <= {bank_reg[1:0], ixe_reg};
			if (depth_reg != viau_pkg::ISTK_FULL) begin
				depth_reg <= depth_reg + 2'h1;
			end
		end else if (return_from_irq_instruction_do) begin
			istk_reg[0] <= istk_reg[1];
			istk_reg[1] <= 3'h0;
			if (depth_reg != 2'h0) begin
				depth_reg <= depth_reg - 2'h1;
			end
		end
	end

	// (R22) Cleared after the push; (R17) low bits restored on return
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bank_reg <= viau_pkg::BANK_RESET;
			ixe_reg <= 1'b0;
		end else if (accept) begin
			bank_reg <= viau_pkg::BANK_RESET;
			ixe_reg <= 1'b0;
		end else if (return_from_irq_instruction_do) begin
			bank_reg <= {bank_reg[3:2], istk_reg[0][2:1]};
			ixe_reg <= istk_reg[0][0];
		end else begin
			if (wr_hit(wb_wr, wb_idx, viau_pkg::IDX_BANK)) begin
				bank_reg <= wb_dat_in[3:0];
			end
			if (wr_hit(wb_wr, wb_idx, viau_pkg::IDX_IXE)) begin
				ixe_reg <= wb_dat_in[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Only byte lane 0 carries data; upper lanes are ignored
	assign wb_req = wb_cyc_in & wb_stb_in & ~ack_reg;
	assign wb_wr = wb_req & wb_we_in & wb_sel_in[0];
	assign wb_idx = wb_adr_in[8:2];

	// One wait state; unmapped addresses read zero and still ack
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req;
		end
	end

	// Read data captured with the acknowledge
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_reg <= 32'h00000000;
		end else if (wb_req && !wb_we_in) begin
			rdata_reg <= 32'h00000000;
			unique case (wb_idx)
				viau_pkg::IDX_SP: rdata_reg[2:0] <= sp_reg;
				viau_pkg::IDX_PERMIT: rdata_reg[3:0] <= permit_reg;
				viau_pkg::IDX_PENDING: rdata_reg[3:0] <= pend_reg;
				viau_pkg::IDX_BANK: rdata_reg[3:0] <= bank_reg;
				viau_pkg::IDX_IXE: rdata_reg[0] <= ixe_reg;
				viau_pkg::IDX_STATUS: begin
					rdata_reg[viau_pkg::ST_GIE] <= gie_reg;
					rdata_reg[viau_pkg::ST_IRQ_CYCLE] <= phase_reg;
					rdata_reg[viau_pkg::ST_EI_ARMED] <= arm_reg;
					rdata_reg[viau_pkg::ST_DEPTH_LSB +: 2] <= depth_reg;
				end
				default: rdata_reg <= 32'h00000000;
			endcase
		end
	end

	// Boundary marker for the sequencer, one clock after the edge
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			boundary_reg <= 1'b0;
		end else begin
			boundary_reg <= cyc_end;
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdata_reg;
	assign cycle_boundary_out = boundary_reg;
	assign irq_cycle_out = phase_reg;
	assign pc_load_out = pc_load_reg;
	assign pc_value_out = pc_value_reg;
	assign stack_pointer_out = sp_reg;
	assign bank_out = bank_reg;
	assign index_enable_out = ixe_reg;
	assign global_irq_enable_out = gie_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence s_accept;
		accept;
	endsequence
	sequence s_vector_load;
		pc_load_out && (pc_value_out == $past(vec_sel));
	endsequence
	sequence s_state_cleared;
		(bank_out == 4'h0) && !index_enable_out && !global_irq_enable_out;
	endsequence

	AST_PEND_SET: assert property ( // (R1)
		(src_req_in != 4'h0) |=> ((pend_reg & $past(src_req_in)) ==
		$past(src_req_in)))
		else $error("request did not set its pending flag");
	AST_PERMIT_ONLY: assert property ( // (R7)
		s_accept |-> ((src.take & ~permit_reg) == 4'h0) && (src.take != 4'h0))
		else $error("accepted a source without permit");
	AST_NEEDS_GIE: assert property ( // (R3)
		s_accept |-> gie_reg && src.any)
		else $error("accepted without enable or request");
	AST_PRIORITY: assert property ( // (R4)
		s_accept |-> (src.take == (src.req & (~src.req + 4'h1))))
		else $error("grant not given to highest pending source");
	AST_DEFER: assert property ( // (R8)
		(cyc_end && (skip_taken_in || table_move_first_in)) |-> !accept)
		else $error("acceptance not deferred");
	AST_EI_LATE: assert property ( // (R9)
		(cyc_end && enable_irq_instruction_in && !gie_reg && !arm_reg &&
		!disable_irq_instruction_in && !accept && !phase_reg) |=>
		!gie_reg [*8])
		else $error("enable took effect too early");
	AST_CLEAR_ONE: assert property ( // (R10)
		(accept && ((src.take & src_req_in) == 4'h0) && !wb_wr) |=>
		((pend_reg & $past(src.take)) == 4'h0) &&
		((pend_reg & ~$past(src.take)) ==
		(($past(pend_reg) | $past(src_req_in)) & ~$past(src.take))))
		else $error("wrong pending flags cleared on accept");
	AST_PUSH_PC: assert property ( // (R11)
		s_accept |=> (sp_reg == $past(sp_reg) - 3'h1) &&
		(astk_reg[sp_reg] == $past(return_pc_in)))
		else $error("return address not pushed below pointer");
	AST_VECTOR: assert property ( // (R14)
		s_accept |=> s_vector_load ##1 !pc_load_out)
		else $error("vector not loaded for one clock");
	AST_STATE_SAVE: assert property ( // (R22)
		s_accept |=> s_state_cleared and (istk_reg[0] ==
		{$past(bank_reg[1:0]), $past(ixe_reg)}))
		else $error("bank and index state not saved and cleared");
	AST_IRQ_CYCLE: assert property ( // (R15)
		s_accept |=> irq_cycle_out [*8] ##0 !accept)
		else $error("interrupt cycle not held");
	AST_ONE_PER_BOUNDARY: assert property ( // (R24)
		accept |-> cyc_end && !irq_cycle_out)
		else $error("accept outside a normal boundary");
	AST_RETURN: assert property ( // (R18)
		return_from_irq_instruction_do |=> (sp_reg == $past(sp_reg) + 3'h1) && pc_load_out &&
		(pc_value_out == $past(astk_top)))
		else $error("return did not restore pc and pointer");
	AST_DI_NOW: assert property ( // (R23)
		disable_irq_instruction_in |=> !global_irq_enable_out)
		else $error("disable did not clear enable at once");
endmodule

//--- include/viau_pkg.sv
// Constants, register map and types of the interrupt acceptance unit
package viau_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYCLE_NS = 2000;
	localparam int CYCLE_IDC_NS = 12000;
	localparam int CYCLE_CLKS = CYCLE_NS / CLK_PERIOD_NS;
	localparam int CYCLE_IDC_CLKS = CYCLE_IDC_NS / CLK_PERIOD_NS;
	localparam logic [11:0] CYC_LAST = 12'(CYCLE_CLKS - 1);
	localparam logic [11:0] CYC_IDC_LAST = 12'(CYCLE_IDC_CLKS - 1);
	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int NSRC = 4;
	localparam int ASTK_DEPTH = 6;
	localparam logic [2:0] SP_RESET = 3'h6;
	localparam logic [2:0] SP_LIMIT = 3'h6;
	localparam logic [1:0] ISTK_FULL = 2'h2;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [3:0] BANK_RESET = 4'h0;
	// Source bit positions, highest hardware priority at bit 0
	localparam int SRC_PIN = 0;
	localparam int SRC_TIMER = 1;
	localparam int SRC_SYNC = 2;
	localparam int SRC_SERIAL = 3;
	typedef logic [11:0] viau_pc_t;
	localparam viau_pc_t VECTOR [NSRC] = '{12'h004, 12'h003, 12'h002, 12'h001};
	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [6:0] IDX_SP = 7'h01;
	localparam logic [6:0] IDX_PERMIT = 7'h2F;
	localparam logic [6:0] IDX_PENDING = 7'h3F;
	localparam logic [6:0] IDX_STATUS = 7'h70;
	localparam logic [6:0] IDX_BANK = 7'h79;
	localparam logic [6:0] IDX_IXE = 7'h7F;
	// Status word fields
	localparam int ST_GIE = 0;
	localparam int ST_IRQ_CYCLE = 1;
	localparam int ST_EI_ARMED = 2;
	localparam int ST_DEPTH_LSB = 4;
	typedef enum logic {
		PH_NORMAL = 1'b0,
		PH_IRQ = 1'b1
	} viau_phase_e;
endpackage

//--- include/viau_src_if.sv
// Per-source flags and grant chain results between control and chain
`timescale 1ns/1ps
interface viau_src_if;
	logic [3:0] pend;
	logic [3:0] permit;
	logic [3:0] req;
	logic [3:0] take;
	logic any;
	modport ctl (output pend, output permit, input req, input take,
		input any);
	modport chain (input pend, input permit, output req, output take,
		output any);
endinterface

//--- logic/viau_grant.sv
// Request blocks and the fixed-priority grant chain
`timescale 1ns/1ps
module viau_grant (
	viau_src_if.chain s
);
	logic [4:0] grant;

	// ----------------------------------------------------------------
	// Chain
	// ----------------------------------------------------------------
	// Grant enters at the highest priority source
	assign grant[0] = 1'b1;
	// (R4) Fixed order, pin first
	generate
		for (genvar i = 0; i < 4; i++) begin : g_blk
			// (R2) Pending and permitted
			assign s.req[i] = s.pend[i] & s.permit[i];
			// (R5) Asserting block absorbs the grant
			assign s.take[i] = grant[i] & s.req[i];
			assign grant[i + 1] = grant[i] & ~s.req[i];
		end
	endgenerate
	// (R3) OR of all request blocks
	assign s.any = |s.req;
endmodule

//--- testbench/viau_seq_model.sv
// Behavioural instruction sequencer and request sources for the unit
`timescale 1ns/1ps
module viau_seq_model (
	input wire logic core_clk_in,
	input wire logic cycle_boundary_in,
	output logic [3:0] src_req_out,
	output logic display_run_out,
	output logic skip_taken_out,
	output logic table_move_first_out,
	output logic enable_irq_out,
	output logic disable_irq_out,
	output logic return_irq_out,
	output logic [11:0] return_pc_out
);
	int span_cnt;
	int span;
	// Idle levels from time zero
	initial begin
		src_req_out = 4'h0;
		{display_run_out, skip_taken_out, table_move_first_out} = 3'h0;
		{enable_irq_out, disable_irq_out, return_irq_out} = 3'h0;
		return_pc_out = 12'h000;
		span_cnt = 0;
	end
	// Clocks between boundary pulses, read half a clock later to avoid a race
	always @(negedge core_clk_in) begin
		if (cycle_boundary_in === 1'b1) begin
			span <= span_cnt;
			span_cnt <= 1;
		end else begin
			span_cnt <= span_cnt + 1;
		end
	end
	// One instruction: levels rise after the last boundary pulse and
	// stay put across the edge that ends it; returns at that pulse
	task automatic exec(input logic [5:0] ctl, input logic [11:0] pc);
		@(posedge core_clk_in);
		{display_run_out, skip_taken_out, table_move_first_out} <= ctl[5:3];
		{enable_irq_out, disable_irq_out, return_irq_out} <= ctl[2:0];
		return_pc_out <= pc;
		do begin
			@(negedge core_clk_in);
		end while (cycle_boundary_in !== 1'b1);
	endtask
	// One-clock request pulse on the chosen sources
	task automatic pulse(input logic [3:0] m);
		@(posedge core_clk_in);
		src_req_out <= m;
		@(posedge core_clk_in);
		src_req_out <= 4'h0;
	endtask
endmodule

//--- testbench/test_vectored_interrupt_acceptance_unit.sv
// Self-checking bench for the interrupt acceptance unit
`timescale 1ns/1ps
module test_vectored_interrupt_acceptance_unit;
	localparam logic [5:0] NO = 6'h00;
	localparam logic [5:0] DISP = 6'h20;
	localparam logic [5:0] SKIP = 6'h10;
	localparam logic [5:0] TMOV = 6'h08;
	localparam logic [5:0] EI = 6'h04;
	localparam logic [5:0] DI = 6'h02;
	localparam logic [5:0] RETURN_FROM_IRQ_INSTRUCTION = 6'h01;
	logic core_clk_in, resetn_in, wb_cyc, wb_stb, wb_we, wb_ack, cb;
	logic [8:0] wb_adr;
	logic [31:0] wb_dat_w, wb_dat_r, rd;
	logic irq_cyc, pc_load, index_enable_system_word, gie, disp, skip, tmov, ei, di, return_from_irq_instruction;
	logic [11:0] pc_val, ret_pc;
	logic [2:0] sp;
	logic [3:0] bank, src;
	int n_errors;
	int tests_run;
	viau_top i_viau_top (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
		.src_req_in(src), .display_run_in(disp), .skip_taken_in(skip),
		.table_move_first_in(tmov), .enable_irq_instruction_in(ei),
		.disable_irq_instruction_in(di),
		.return_from_irq_instruction_in(return_from_irq_instruction), .return_pc_in(ret_pc),
		.wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
		.wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_dat_w),
		.wb_dat_out(wb_dat_r), .wb_ack_out(wb_ack),
		.cycle_boundary_out(cb), .irq_cycle_out(irq_cyc),
		.pc_load_out(pc_load), .pc_value_out(pc_val),
		.stack_pointer_out(sp), .bank_out(bank), .index_enable_out(index_enable_system_word),
		.global_irq_enable_out(gie));
	viau_seq_model i_viau_seq_model (.core_clk_in(core_clk_in),
		.cycle_boundary_in(cb), .src_req_out(src), .display_run_out(disp),
		.skip_taken_out(skip), .table_move_first_out(tmov),
		.enable_irq_out(ei), .disable_irq_out(di), .return_irq_out(return_from_irq_instruction),
		.return_pc_out(ret_pc));
	// ------
	// Helpers
	// ------
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle; waits for ack, the watchdog bounds a hang
	task automatic wb(input logic we, input logic [6:0] idx,
		input logic [31:0] wd);
		@(posedge core_clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'h0};
		wb_dat_w <= wd;
		do begin
			@(posedge core_clk_in);
		end while (wb_ack !== 1'b1);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask
	// Packed view of the sequencer-facing outputs
	function automatic logic [31:0] now_st();
		return {9'h0, irq_cyc, pc_load, gie, index_enable_system_word, bank, sp, pc_val};
	endfunction
	function automatic logic [31:0] st(input logic i, l, g, x,
		input logic [3:0] b, input logic [2:0] s, input logic [11:0] p);
		return {9'h0, i, l, g, x, b, s, p};
	endfunction
	task automatic ex(input logic [5:0] c, input logic [11:0] p,
		input logic [31:0] exp);
		i_viau_seq_model.exec(c, p);
		chk(now_st(), exp);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_reset();
		chk(now_st(), st(0, 0, 0, 0, 4'h0, 3'h6, 12'h000));
		rdc(viau_pkg::IDX_SP, 32'h6);
		rdc(viau_pkg::IDX_PENDING, 32'h0);
		rdc(viau_pkg::IDX_STATUS, 32'h0);
		wb(1'b1, 7'h10, 32'hF);
		rdc(7'h10, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_pending();
		i_viau_seq_model.pulse(4'hF);
		rdc(viau_pkg::IDX_PENDING, 32'hF);
		// Pin masked so a lower source must win
		wb(1'b1, viau_pkg::IDX_PERMIT, 32'hE);
		rdc(viau_pkg::IDX_PERMIT, 32'hE);
		ex(NO, 12'h000, st(0, 0, 0, 0, 4'h0, 3'h6, 12'h000));
		$display("test pending done");
	endtask
	task automatic t_accept();
		wb(1'b1, viau_pkg::IDX_BANK, 32'h7);
		wb(1'b1, viau_pkg::IDX_IXE, 32'h1);
		ex(EI, 12'h000, st(0, 0, 0, 1, 4'h7, 3'h6, 12'h000));
		ex(NO, 12'h000, st(0, 0, 1, 1, 4'h7, 3'h6, 12'h000));
		ex(NO, 12'h123, st(1, 1, 0, 0, 4'h0, 3'h5, 12'h003));
		rdc(viau_pkg::IDX_PENDING, 32'hD);
		rdc(viau_pkg::IDX_STATUS, 32'h12);
		// Enable inside the interrupt cycle is ignored
		ex(EI, 12'h000, st(0, 0, 0, 0, 4'h0, 3'h5, 12'h003));
		wb(1'b1, viau_pkg::IDX_BANK, 32'h2);
		ex(EI, 12'h000, st(0, 0, 0, 0, 4'h2, 3'h5, 12'h003));
		ex(NO, 12'h000, st(0, 0, 1, 0, 4'h2, 3'h5, 12'h003));
		ex(NO, 12'h456, st(1, 1, 0, 0, 4'h0, 3'h4, 12'h002));
		ex(NO, 12'h000, st(0, 0, 0, 0, 4'h0, 3'h4, 12'h002));
		ex(RETURN_FROM_IRQ_INSTRUCTION, 12'h000, st(0, 1, 0, 0, 4'h2, 3'h5, 12'h456));
		ex(RETURN_FROM_IRQ_INSTRUCTION, 12'h000, st(0, 1, 0, 1, 4'h3, 3'h6, 12'h123));
		rdc(viau_pkg::IDX_PENDING, 32'h9);
		$display("test accept done");
	endtask
	task automatic t_defer();
		ex(EI, 12'h000, st(0, 0, 0, 1, 4'h3, 3'h6, 12'h123));
		rdc(viau_pkg::IDX_STATUS, 32'h4);
		ex(NO, 12'h000, st(0, 0, 1, 1, 4'h3, 3'h6, 12'h123));
		ex(SKIP, 12'h000, st(0, 0, 1, 1, 4'h3, 3'h6, 12'h123));
		ex(TMOV, 12'h000, st(0, 0, 1, 1, 4'h3, 3'h6, 12'h123));
		ex(DI, 12'h000, st(0, 0, 0, 1, 4'h3, 3'h6, 12'h123));
		ex(EI, 12'h000, st(0, 0, 0, 1, 4'h3, 3'h6, 12'h123));
		ex(NO, 12'h000, st(0, 0, 1, 1, 4'h3, 3'h6, 12'h123));
		ex(NO, 12'h200, st(1, 1, 0, 0, 4'h0, 3'h5, 12'h001));
		ex(NO, 12'h000, st(0, 0, 0, 0, 4'h0, 3'h5, 12'h001));
		ex(RETURN_FROM_IRQ_INSTRUCTION, 12'h000, st(0, 1, 0, 1, 4'h3, 3'h6, 12'h200));
		rdc(viau_pkg::IDX_PENDING, 32'h1);
		$display("test defer done");
	endtask
	task automatic t_display();
		i_viau_seq_model.exec(DISP, 12'h000);
		i_viau_seq_model.exec(NO, 12'h000);
		@(posedge core_clk_in);
		chk(32'(i_viau_seq_model.span), 32'hBB8);
		i_viau_seq_model.exec(NO, 12'h000);
		@(posedge core_clk_in);
		chk(32'(i_viau_seq_model.span), 32'h1F4);
		$display("test display done");
	endtask
	// ------
	// Main sequence and watchdog
	// ------
	initial begin
		n_errors = 0;
		tests_run = 0;
		resetn_in = 1'b0;
		{wb_cyc, wb_stb, wb_we} = 3'h0;
		wb_adr = 9'h000;
		wb_dat_w = 32'h0;
		repeat (3) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		t_reset();
		t_pending();
		t_accept();
		t_defer();
		t_display();
		print_verdict();
	end
	// Whole run needs roughly 14500 clocks
	initial begin
		repeat (40000) @(posedge core_clk_in);
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		print_verdict();
	end
endmodule
